/* File: logic/fcs_top.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module fcs_top #(
    parameter logic [15:0] ARR_LO = fcs_pkg::ARR_BASE
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [7:0]  rdata,
    input  wire logic        bdm_access,
    input  wire logic        secured,
    input  wire logic        stop_mode,
    input  wire logic [7:0]  nonvolatile_protection_image,
    input  wire logic        vec_fetch,
    input  wire logic [15:0] vec_addr,
    output logic      [15:0] vec_addr_redir,
    output logic             pump_on,
    output logic             op_active,
    output logic      [7:0]  op_cmd,
    output logic      [15:0] op_addr,
    output logic      [7:0]  op_data
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (ARR_LO[5:0] != 6'h00) begin : g_bad_base
        $error("ARR_LO must be row aligned");
    end

    fcs_pkg::fcs_state_t st_ff;
    fcs_pkg::fcs_state_t nxt_st;

    logic        err;
    logic        stop_err;
    logic        launch;
    logic        ctrl_hit;
    logic        arr_hit;
    logic        tick;
    logic        pre_wrap;
    logic        done;
    logic        chain;
    logic        code_ok;
    logic        prot_err;
    logic        prot_any;
    logic        prot_hit;
    logic        prot_whole;
    logic [16:0] blk_size;
    logic [16:0] blk_start;

    // ----------------------------------------------------------------
    // Cycle count per command
    // ----------------------------------------------------------------
    function automatic logic [14:0] cyc_of(input logic [7:0] c);
        logic [14:0] r;
        r = fcs_pkg::CYC_PROG;
        case (c)
            fcs_pkg::CMD_BLANK: r = fcs_pkg::CYC_BLANK;
            fcs_pkg::CMD_PAGE:  r = fcs_pkg::CYC_PAGE;
            fcs_pkg::CMD_MASS:  r = fcs_pkg::CYC_MASS;
            default:            r = fcs_pkg::CYC_PROG;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st   = st_ff;
        err      = 1'b0;
        stop_err = 1'b0;
        launch   = 1'b0;
        done     = 1'b0;
        chain    = 1'b0;
        prot_err = 1'b0;
        ctrl_hit = (addr == fcs_pkg::ADR_DIV) || (addr == fcs_pkg::ADR_PROT) ||
                   (addr == fcs_pkg::ADR_STAT) || (addr == fcs_pkg::ADR_CMD);
        arr_hit  = addr >= ARR_LO;
        code_ok  = (wdata == fcs_pkg::CMD_BLANK) || (wdata == fcs_pkg::CMD_PROG) ||
                   (wdata == fcs_pkg::CMD_BURST) || (wdata == fcs_pkg::CMD_PAGE) ||
                   (wdata == fcs_pkg::CMD_MASS);

        // Protection decode
        prot_whole = !st_ff.prot[fcs_pkg::PR_OPEN];
        blk_size   = 17'(fcs_pkg::PROT_UNIT << st_ff.prot[fcs_pkg::PR_SZ_HI:fcs_pkg::PR_SZ_LO]);
        blk_start  = 17'(fcs_pkg::MEM_TOP - blk_size);
        prot_any   = prot_whole || !st_ff.prot[fcs_pkg::PR_DIS];
        prot_hit   = prot_whole ||
                     (!st_ff.prot[fcs_pkg::PR_DIS] && ({1'b0, st_ff.b_addr} >= blk_start));

        // Memory timing clock
        pre_wrap = !st_ff.prdiv8 || (st_ff.pre == 3'h7);
        tick     = st_ff.divld && pre_wrap && (st_ff.dcnt == st_ff.div);
        if (st_ff.divld) begin
            nxt_st.pre  = st_ff.prdiv8 ? 3'(st_ff.pre + 3'h1) : 3'h0;
            nxt_st.dcnt = !pre_wrap ? st_ff.dcnt : (tick ? 6'h00 : 6'(st_ff.dcnt + 6'h01));
        end

        // Array write, first step
        if (wr_stb && arr_hit && !st_ff.accerr) begin
            if (!st_ff.divld) err = 1'b1;
            if (st_ff.q) err = 1'b1;
            if (st_ff.ph != fcs_pkg::PH_EMPTY) err = 1'b1;
            if (!err) begin
                nxt_st.ph     = fcs_pkg::PH_ADDR;
                nxt_st.b_addr = addr;
                nxt_st.b_data = wdata;
            end
        end

        // Control access after the array write
        if (wr_stb && ctrl_hit && addr != fcs_pkg::ADR_CMD && st_ff.ph == fcs_pkg::PH_ADDR) begin
            err = 1'b1;
        end
        if ((wr_stb || rd_stb) && ctrl_hit && st_ff.ph == fcs_pkg::PH_CMD &&
            !(wr_stb && addr == fcs_pkg::ADR_STAT && wdata[fcs_pkg::ST_CBEF])) begin
            err = 1'b1;
        end

        // Command code
        if (wr_stb && addr == fcs_pkg::ADR_CMD && !st_ff.accerr) begin
            if (st_ff.ph != fcs_pkg::PH_ADDR) begin
                err = 1'b1;
            end else if (!code_ok) begin
                err = 1'b1;
            end else if (bdm_access && secured && (wdata == fcs_pkg::CMD_PROG ||
                         wdata == fcs_pkg::CMD_BURST || wdata == fcs_pkg::CMD_PAGE)) begin
                err = 1'b1;
            end else begin
                nxt_st.ph    = fcs_pkg::PH_CMD;
                nxt_st.b_cmd = wdata;
            end
        end

        // Status write: launch or cancel
        if (wr_stb && addr == fcs_pkg::ADR_STAT) begin
            if (!wdata[fcs_pkg::ST_CBEF] && st_ff.ph != fcs_pkg::PH_EMPTY) begin
                err = 1'b1;
            end
            if (wdata[fcs_pkg::ST_CBEF] && st_ff.ph == fcs_pkg::PH_CMD &&
                !st_ff.accerr) begin
                launch    = 1'b1;
                nxt_st.ph = fcs_pkg::PH_EMPTY;
                if ((st_ff.b_cmd == fcs_pkg::CMD_MASS && prot_any) ||
                    (st_ff.b_cmd != fcs_pkg::CMD_MASS && st_ff.b_cmd != fcs_pkg::CMD_BLANK &&
                     prot_hit)) begin
                    prot_err = 1'b1;
                end else begin
                    nxt_st.q = 1'b1;
                end
            end
        end

        // Divider written once
        if (wr_stb && addr == fcs_pkg::ADR_DIV && !st_ff.divld && !st_ff.accerr &&
            st_ff.ph == fcs_pkg::PH_EMPTY) begin
            nxt_st.divld  = 1'b1;
            nxt_st.prdiv8 = wdata[fcs_pkg::DIV_PRE];
            nxt_st.div    = wdata[5:0];
        end

        // Protection: debug path writes, plus the one image load after reset
        if (wr_stb && addr == fcs_pkg::ADR_PROT && bdm_access &&
            st_ff.ph == fcs_pkg::PH_EMPTY) begin
            nxt_st.prot = wdata;
        end
        if (!st_ff.prot_ld) begin
            nxt_st.prot    = nonvolatile_protection_image;
            nxt_st.prot_ld = 1'b1;
        end

        if (err) nxt_st.ph = fcs_pkg::PH_EMPTY;

        // Command executor
        case (st_ff.state)
            fcs_pkg::S_IDLE: begin
                if (st_ff.q) begin
                    nxt_st.state    = fcs_pkg::S_RUN;
                    nxt_st.q        = 1'b0;
                    nxt_st.cur_addr = st_ff.b_addr;
                    nxt_st.cur_data = st_ff.b_data;
                    nxt_st.cur_cmd  = st_ff.b_cmd;
                    nxt_st.cnt      = cyc_of(st_ff.b_cmd);
                    nxt_st.pump     = st_ff.b_cmd != fcs_pkg::CMD_BLANK;
                end
            end
            fcs_pkg::S_RUN: begin
                done  = tick && (st_ff.cnt == 15'h0001);
                chain = st_ff.cur_cmd == fcs_pkg::CMD_BURST && st_ff.q &&
                        st_ff.b_cmd == fcs_pkg::CMD_BURST &&
                        st_ff.b_addr[15:fcs_pkg::ROW_BITS] ==
                        st_ff.cur_addr[15:fcs_pkg::ROW_BITS] &&
                        st_ff.b_addr[fcs_pkg::ROW_BITS-1:0] != 6'h00;
                if (stop_mode && st_ff.cur_cmd != fcs_pkg::CMD_BLANK) begin
                    stop_err     = 1'b1;
                    nxt_st.state = fcs_pkg::S_IDLE;
                    nxt_st.pump  = 1'b0;
                    nxt_st.q     = 1'b0;
                end else if (done && chain) begin
                    nxt_st.q        = 1'b0;
                    nxt_st.cur_addr = st_ff.b_addr;
                    nxt_st.cur_data = st_ff.b_data;
                    nxt_st.cnt      = fcs_pkg::CYC_BURST;
                end else if (done) begin
                    nxt_st.state = fcs_pkg::S_IDLE;
                    nxt_st.pump  = 1'b0;
                end else if (tick) begin
                    nxt_st.cnt = 15'(st_ff.cnt - 15'h0001);
                end
            end
            default: begin
                nxt_st.state = fcs_pkg::S_IDLE;
                nxt_st.pump  = 1'b0;
            end
        endcase
        nxt_st.ccf = (nxt_st.state == fcs_pkg::S_IDLE) && !nxt_st.q;

        // Sticky flags: a set wins over the clear
        nxt_st.accerr = (st_ff.accerr &
                         !(wr_stb && addr == fcs_pkg::ADR_STAT && wdata[fcs_pkg::ST_ACCERR]))
                        | err | stop_err;
        nxt_st.pviol  = (st_ff.pviol &
                         !(wr_stb && addr == fcs_pkg::ADR_STAT && wdata[fcs_pkg::ST_PVIOL]))
                        | (launch && prot_err);

        // Register read
        nxt_st.rdata = 8'h00;
        if (rd_stb) begin
            case (addr)
                fcs_pkg::ADR_DIV:  nxt_st.rdata = {st_ff.divld, st_ff.prdiv8, st_ff.div};
                fcs_pkg::ADR_PROT: nxt_st.rdata = st_ff.prot;
                fcs_pkg::ADR_STAT: nxt_st.rdata = {!st_ff.q, st_ff.ccf, st_ff.pviol,
                                                   st_ff.accerr, 4'h0};
                fcs_pkg::ADR_CMD:  nxt_st.rdata = st_ff.b_cmd;
                default:           nxt_st.rdata = 8'h00;
            endcase
        end

        // Vector redirection
        nxt_st.vec = vec_addr;
        if (vec_fetch && st_ff.prot[fcs_pkg::PR_OPEN] && !st_ff.prot[fcs_pkg::PR_DIS] &&
            vec_addr >= fcs_pkg::VEC_LO && vec_addr <= fcs_pkg::VEC_HI) begin
            nxt_st.vec = 16'(vec_addr - blk_size[15:0]);
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_ff        <= '0;
            st_ff.state  <= fcs_pkg::S_IDLE;
            st_ff.prot   <= fcs_pkg::RST_PROT;
            st_ff.div    <= fcs_pkg::RST_DIV;
            st_ff.ccf    <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata          = st_ff.rdata;
    assign vec_addr_redir = st_ff.vec;
    assign pump_on        = st_ff.pump;
    assign op_active      = st_ff.state == fcs_pkg::S_RUN;
    assign op_cmd         = st_ff.cur_cmd;
    assign op_addr        = st_ff.cur_addr;
    assign op_data        = st_ff.cur_data;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_launch_write;
        wr_stb && addr == fcs_pkg::ADR_STAT && wdata[fcs_pkg::ST_CBEF];
    endsequence

    a_launch_needs_clear: assert property ($rose(st_ff.q) |->
        $past(!st_ff.accerr && st_ff.ph == fcs_pkg::PH_CMD))
        else $error("command queued while error flag set");
    a_clear_by_one: assert property ($fell(st_ff.accerr) |->
        $past(wr_stb && addr == fcs_pkg::ADR_STAT && wdata[fcs_pkg::ST_ACCERR]))
        else $error("error flag cleared without a one write");
    a_no_divider_err: assert property (wr_stb && arr_hit && !st_ff.divld |=>
        st_ff.accerr && st_ff.ph == fcs_pkg::PH_EMPTY)
        else $error("array write before divider not flagged");
    a_bad_code_err: assert property (wr_stb && addr == fcs_pkg::ADR_CMD &&
        st_ff.ph == fcs_pkg::PH_ADDR && !st_ff.accerr && !code_ok |=> st_ff.accerr)
        else $error("invalid command code not flagged");
    a_cancel_err: assert property (wr_stb && addr == fcs_pkg::ADR_STAT &&
        !wdata[fcs_pkg::ST_CBEF] && st_ff.ph != fcs_pkg::PH_EMPTY |=> st_ff.accerr ##1 !st_ff.q)
        else $error("cancel did not set error flag");
    a_pump_drop: assert property (st_ff.state == fcs_pkg::S_RUN && done && !chain &&
        !stop_mode |=> !pump_on && !op_active)
        else $error("pump left on with nothing queued");
    a_burst_keep: assert property (st_ff.state == fcs_pkg::S_RUN && done && chain &&
        !stop_mode |=> pump_on && op_active && st_ff.cnt == fcs_pkg::CYC_BURST)
        else $error("burst chain lost pump or timing");
    a_stop_abort: assert property (op_active && stop_mode &&
        op_cmd != fcs_pkg::CMD_BLANK |=> st_ff.accerr && !op_active && !pump_on)
        else $error("stop did not abort command");
    a_prot_debug_only: assert property (st_ff.prot_ld && $past(st_ff.prot_ld) &&
        $changed(st_ff.prot) |->
        $past(wr_stb && bdm_access && addr == fcs_pkg::ADR_PROT))
        else $error("protection changed without debug write");
    a_reset_vec_kept: assert property (vec_addr > fcs_pkg::VEC_HI |=>
        vec_addr_redir == $past(vec_addr))
        else $error("reset vector was redirected");
    a_mass_refused: assert property (s_launch_write and ##0 (st_ff.ph == fcs_pkg::PH_CMD &&
        st_ff.b_cmd == fcs_pkg::CMD_MASS && prot_any) |=> !st_ff.q && st_ff.pviol)
        else $error("mass erase launched under protection");

endmodule

/* File: pkg/fcs_pkg.sv */
package fcs_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [15:0] ADR_DIV    = 16'h1820;
    localparam logic [15:0] ADR_PROT   = 16'h1824;
    localparam logic [15:0] ADR_STAT   = 16'h1825;
    localparam logic [15:0] ADR_CMD    = 16'h1826;
    localparam logic [15:0] ADR_NONVOLATILE_PROTECTION_IMAGE = 16'hFFBD;
    localparam logic [15:0] ARR_BASE   = 16'h8000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ST_CBEF   = 7;
    localparam int ST_CCF    = 6;
    localparam int ST_PVIOL  = 5;
    localparam int ST_ACCERR = 4;
    localparam int DIV_PRE   = 6;
    localparam int PR_OPEN   = 7;
    localparam int PR_DIS    = 6;
    localparam int PR_SZ_HI  = 5;
    localparam int PR_SZ_LO  = 3;
    localparam int ROW_BITS  = 6;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_PROG  = 8'h20;
    localparam logic [7:0] CMD_BURST = 8'h25;
    localparam logic [7:0] CMD_PAGE  = 8'h40;
    localparam logic [7:0] CMD_MASS  = 8'h41;

    // ----------------------------------------------------------------
    // Timing counts in memory clock cycles
    // ----------------------------------------------------------------
    localparam logic [14:0] CYC_PROG  = 15'h0009;
    localparam logic [14:0] CYC_BURST = 15'h0004;
    localparam logic [14:0] CYC_PAGE  = 15'h0FA0;
    localparam logic [14:0] CYC_MASS  = 15'h4E20;
    localparam logic [14:0] CYC_BLANK = 15'h0001;

    // ----------------------------------------------------------------
    // Protection geometry and vectors
    // ----------------------------------------------------------------
    localparam logic [16:0] PROT_UNIT = 17'h00200;
    localparam logic [16:0] MEM_TOP   = 17'h10000;
    localparam logic [15:0] VEC_LO    = 16'hFFC0;
    localparam logic [15:0] VEC_HI    = 16'hFFFD;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PROT = 8'hC0;
    localparam logic [5:0] RST_DIV  = 6'h00;

    // ----------------------------------------------------------------
    // Command build phases and states
    // ----------------------------------------------------------------
    localparam logic [1:0] PH_EMPTY = 2'h0;
    localparam logic [1:0] PH_ADDR  = 2'h1;
    localparam logic [1:0] PH_CMD   = 2'h2;

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_RUN  = 2'b10
    } fcs_fsm_t;

    typedef struct packed {
        fcs_fsm_t    state;
        logic [1:0]  ph;
        logic [15:0] b_addr;
        logic [7:0]  b_data;
        logic [7:0]  b_cmd;
        logic        q;
        logic        divld;
        logic        prdiv8;
        logic [5:0]  div;
        logic [2:0]  pre;
        logic [5:0]  dcnt;
        logic        accerr;
        logic        pviol;
        logic        ccf;
        logic [7:0]  prot;
        logic        prot_ld;
        logic [15:0] cur_addr;
        logic [7:0]  cur_data;
        logic [7:0]  cur_cmd;
        logic [14:0] cnt;
        logic        pump;
        logic [7:0]  rdata;
        logic [15:0] vec;
    } fcs_state_t;

endpackage

/* File: dv/fcs_host.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bus master model
// ------------------------------------------------------------
module fcs_host (
    input  wire logic        clk_sys,
    input  wire logic [7:0]  rdata,
    output logic      [15:0] addr,
    output logic      [7:0]  wdata,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic             bdm_access
);
    initial begin
        addr       = 16'h0000;
        wdata      = 8'h00;
        wr_stb     = 1'b0;
        rd_stb     = 1'b0;
        bdm_access = 1'b0;
    end

    // Released bus lines flip so no stale value lingers
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        addr   <= ~a;
        wdata  <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        addr   <= ~a;
        @(posedge clk_sys);
        d = rdata;
    endtask

    task automatic cmd(input logic [15:0] a, input logic [7:0] c);
        wr(a, 8'h5A);
        wr(fcs_pkg::ADR_CMD, c);
        wr(fcs_pkg::ADR_STAT, 8'h80);
    endtask

    task automatic set_bdm(input logic b);
        @(posedge clk_sys);
        bdm_access <= b;
    endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------
    // Signals and case table
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] a1;
        logic [7:0]  d1;
        logic [15:0] a2;
        logic [7:0]  d2;
        logic        rd2;
        logic [7:0]  st;
        logic [7:0]  op;
        logic [15:0] len;
    } fcs_row_t;
    logic        clk_sys   = 1'b0;
    logic        arst_n    = 1'b0;
    logic        secured   = 1'b0;
    logic        stop_mode = 1'b0;
    logic        vec_fetch = 1'b0;
    logic [15:0] vec_addr  = 16'hFFE0;
    logic [7:0]  nv_img    = 8'hC0;
    logic [15:0] addr, op_addr, vec_addr_redir, seen_addr;
    logic [7:0]  wdata, rdata, op_cmd, op_data, rd_val, seen_cmd, seen_data;
    logic        wr_stb, rd_stb, bdm_access, pump_on, op_active;
    int          n_fail      = 0;
    int          check_count = 0;
    int          n1;
    int          n2;
    fcs_row_t    rows[11]    = '{
        '{fcs_pkg::ADR_CMD, 8'h20, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h80, 8'h20, 16'h0009},
        '{fcs_pkg::ADR_CMD, 8'h05, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h80, 8'h05, 16'h0001},
        '{fcs_pkg::ADR_CMD, 8'h40, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h80, 8'h40, 16'h0FA0},
        '{fcs_pkg::ADR_CMD, 8'h41, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h80, 8'h41, 16'h4E20},
        '{fcs_pkg::ADR_CMD, 8'h25, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h80, 8'h25, 16'h0009},
        '{fcs_pkg::ADR_CMD, 8'h33, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h90, 8'h00, 16'h0000},
        '{16'h8011,         8'h00, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h90, 8'h00, 16'h0000},
        '{fcs_pkg::ADR_CMD, 8'h20, fcs_pkg::ADR_CMD,  8'h20, 1'b0, 8'h90, 8'h00, 16'h0000},
        '{fcs_pkg::ADR_DIV, 8'h00, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h90, 8'h00, 16'h0000},
        '{fcs_pkg::ADR_CMD, 8'h20, fcs_pkg::ADR_STAT, 8'h00, 1'b1, 8'h90, 8'h00, 16'h0000},
        '{fcs_pkg::ADR_STAT, 8'h00, fcs_pkg::ADR_STAT, 8'h80, 1'b0, 8'h90, 8'h00, 16'h0000}};

    always #5 clk_sys = ~clk_sys;

    fcs_top u_fcs_top (
        .clk_sys                      (clk_sys),
        .arst_n                       (arst_n),
        .addr                         (addr),
        .wdata                        (wdata),
        .wr_stb                       (wr_stb),
        .rd_stb                       (rd_stb),
        .rdata                        (rdata),
        .bdm_access                   (bdm_access),
        .secured                      (secured),
        .stop_mode                    (stop_mode),
        .nonvolatile_protection_image (nv_img),
        .vec_fetch                    (vec_fetch),
        .vec_addr                     (vec_addr),
        .vec_addr_redir               (vec_addr_redir),
        .pump_on                      (pump_on),
        .op_active                    (op_active),
        .op_cmd                       (op_cmd),
        .op_addr                      (op_addr),
        .op_data                      (op_data)
    );

    fcs_host u_fcs_host (
        .clk_sys    (clk_sys),
        .rdata      (rdata),
        .addr       (addr),
        .wdata      (wdata),
        .wr_stb     (wr_stb),
        .rd_stb     (rd_stb),
        .bdm_access (bdm_access)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic rst(input logic [7:0] img);
        arst_n <= 1'b0;
        nv_img <= img;
        repeat (2) @(posedge clk_sys);
        chk("rst_pump", 16'(pump_on), 16'h0000);
        chk("rst_op", 16'(op_active), 16'h0000);
        arst_n <= 1'b1;
    endtask

    // Waits for pump or operation, then counts its high cycles
    task automatic run_len(input logic p, output int n);
        int k;
        n = 0;
        for (k = 0; k < 16 && (p ? pump_on : op_active) !== 1'b1; k++)
            @(posedge clk_sys);
        seen_cmd  = op_cmd;
        seen_addr = op_addr;
        seen_data = op_data;
        while ((p ? pump_on : op_active) === 1'b1 && n < 25000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    task automatic stat(input logic [7:0] e, input logic [7:0] m);
        u_fcs_host.rd(fcs_pkg::ADR_STAT, rd_val);
        chk("status", 16'(rd_val & m), 16'(e));
        u_fcs_host.wr(fcs_pkg::ADR_STAT, 8'h30);
    endtask

    task automatic burst(input logic [15:0] a1, a2, e1, e2);
        fork
            run_len(1'b1, n1);
            begin
                u_fcs_host.cmd(a1, 8'h25);
                @(posedge clk_sys);
                u_fcs_host.cmd(a2, 8'h25);
            end
        join
        run_len(1'b1, n2);
        chk("pump_run1", 16'(n1), e1);
        chk("pump_run2", 16'(n2), e2);
        $display("burst %h done", a2);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        rst(8'hC0);
        u_fcs_host.wr(16'h8000, 8'h11);
        stat(8'h90, 8'hB0);
        stat(8'h80, 8'hB0);
        u_fcs_host.wr(fcs_pkg::ADR_DIV, 8'h00);
        foreach (rows[i]) begin
            u_fcs_host.wr(16'h8010, 8'h3C);
            u_fcs_host.wr(rows[i].a1, rows[i].d1);
            if (rows[i].rd2)
                u_fcs_host.rd(rows[i].a2, rd_val);
            else
                u_fcs_host.wr(rows[i].a2, rows[i].d2);
            run_len(1'b0, n1);
            chk("op_len", 16'(n1), rows[i].len);
            if (rows[i].len != 16'h0000) begin
                chk("op_cmd", 16'(seen_cmd), 16'(rows[i].op));
                chk("op_addr", seen_addr, 16'h8010);
                chk("op_data", 16'(seen_data), 16'h003C);
            end
            stat(rows[i].st, 8'hB0);
            $display("row %0d done", i);
        end
        burst(16'h8001, 16'h8002, 16'h000D, 16'h0000);
        burst(16'h803F, 16'h8040, 16'h0009, 16'h0009);
        secured <= 1'b1;
        u_fcs_host.set_bdm(1'b1);
        u_fcs_host.cmd(16'h8010, 8'h20);
        stat(8'h90, 8'hB0);
        u_fcs_host.cmd(16'h8010, 8'h05);
        run_len(1'b0, n1);
        chk("blank_len", 16'(n1), 16'h0001);
        u_fcs_host.set_bdm(1'b0);
        secured <= 1'b0;
        stat(8'h80, 8'hB0);
        u_fcs_host.cmd(16'h8200, 8'h40);
        @(posedge clk_sys);
        u_fcs_host.cmd(16'h8300, 8'h20);
        u_fcs_host.wr(16'h8400, 8'h00);
        stat(8'h10, 8'h10);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("abort", 16'(op_active), 16'h0000);
        stop_mode <= 1'b0;
        stat(8'h10, 8'h10);
        $display("error cases done");
        rst(8'h88);
        u_fcs_host.rd(fcs_pkg::ADR_PROT, rd_val);
        chk("prot_load", 16'(rd_val), 16'h0088);
        u_fcs_host.wr(fcs_pkg::ADR_PROT, 8'hC0);
        u_fcs_host.rd(fcs_pkg::ADR_PROT, rd_val);
        chk("prot_app", 16'(rd_val), 16'h0088);
        vec_fetch <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("vec_irq", vec_addr_redir, 16'hFBE0);
        vec_addr <= 16'hFFFE;
        repeat (2) @(posedge clk_sys);
        chk("vec_rst", vec_addr_redir, 16'hFFFE);
        vec_fetch <= 1'b0;
        u_fcs_host.wr(fcs_pkg::ADR_DIV, 8'h00);
        u_fcs_host.cmd(16'hFC10, 8'h20);
        stat(8'hA0, 8'hB0);
        u_fcs_host.cmd(16'h8010, 8'h41);
        run_len(1'b0, n1);
        chk("mass_prot", 16'(n1), 16'h0000);
        stat(8'hA0, 8'hB0);
        u_fcs_host.set_bdm(1'b1);
        u_fcs_host.wr(fcs_pkg::ADR_PROT, 8'h40);
        u_fcs_host.set_bdm(1'b0);
        u_fcs_host.cmd(16'h8010, 8'h20);
        stat(8'hA0, 8'hB0);
        $display("protection done");
        end_of_test();
    end

    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end
endmodule
